// ==== lane_pcs_mode_switch_regs_tb.sv ====
// Self-checking bench for the lane PCS mode switch registers.
// Assumes lpms_apb_model drives the APB side on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lane_pcs_mode_switch_regs_tb;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  k_pin, enc_k;
    logic [15:0] disp_pin, enc_disp;
    logic [3:0]  enc_sel, fab_sel, hdr;
    logic [1:0]  gear, frx, ftx, irx, itx, fwr, frd;
    logic [2:0]  ser, des;
    logic        wclk_pin, swap, side, rxr, txr, align, sos, eidle, byp;
    logic        wclk_sel, e;
    int          err_total = 0;
    int          tests_run = 0;
    lpms_apb_model lpms_apb_model_inst (.core_clk(core_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lpms_regs lpms_regs_inst (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fab_tx_ctrl_k(k_pin),
        .fab_tx_disp_ctrl(disp_pin), .tx_word_clk_pin(wclk_pin),
        .lane_encoding_path_select(enc_sel), .fabric_path_select(fab_sel),
        .octet_swap_select(swap), .fifo_gear_width(gear),
        .fabric_rx_clock_source(frx), .fabric_tx_clock_source(ftx),
        .internal_rx_clock_source(irx), .internal_tx_clock_source(itx),
        .rx_fifo_write_clock_source(fwr), .tx_fifo_read_clock_source(frd),
        .rx_fifo_clock_side_select(side), .serializer_width_select(ser),
        .deserializer_width_select(des), .pcs_rx_soft_rst(rxr),
        .pcs_tx_soft_rst(txr), .aligner_search_start(align),
        .enc_ctrl_k(enc_k), .enc_disp_ctrl(enc_disp), .blk_hdr(hdr),
        .blk_sos(sos), .blk_elec_idle(eidle), .blk_bypass(byp),
        .tx_word_clk_sel(wclk_sel));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        lpms_apb_model_inst.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        lpms_apb_model_inst.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic t_reset();
        rd(lpms_pkg::OFF_SWAP_GEAR);
        chk("swap_gear", lpms_pkg::RST_SWAP_GEAR, q);
        rd(lpms_pkg::OFF_PATH);
        chk("path", lpms_pkg::RST_PATH, q);
        rd(lpms_pkg::OFF_CLK);
        chk("clk", lpms_pkg::RST_CLK, q);
        rd(lpms_pkg::OFF_CTRL);
        chk("ctrl", lpms_pkg::RST_CTRL, q);
        chk("clk_out", 32'haf5, {side, frd, fwr, itx, irx, ftx, frx});
        $display("test reset done");
    endtask : t_reset
    task automatic t_to64();
        wr(lpms_pkg::OFF_SWAP_GEAR, 32'h7);
        lpms_apb_model_inst.switch_mode(1'b1);
        chk("done64", 32'h1, lpms_apb_model_inst.switch_done);
        chk("path64", 32'h22, {enc_sel, fab_sel});
        chk("swap_gear64", 32'h0, {swap, gear});
        chk("width64", 32'h36, {ser, des});
        chk("soft_rst64", 32'h0, {rxr, txr});
        chk("clk64", 32'haf5, {side, frd, fwr, itx, irx, ftx, frx});
        {k_pin, disp_pin} = {8'hff, 16'hc000};
        @(posedge core_clk);
        #1 chk("blk64", 32'h7f, {hdr, sos, eidle, byp});
        chk("enc64", 32'h0, {enc_k, enc_disp});
        $display("test to64 done");
    endtask : t_to64
    task automatic t_to8();
        lpms_apb_model_inst.switch_mode(1'b0);
        chk("done8", 32'h1, lpms_apb_model_inst.switch_done);
        chk("path8", 32'h44, {enc_sel, fab_sel});
        chk("swap_gear8", 32'h7, {swap, gear});
        chk("width8", 32'h3f, {ser, des});
        // Pulse follows the edge after the releasing write lands
        chk("align_early", 32'h0, align);
        {k_pin, disp_pin} = {8'ha5, 16'h1234};
        @(posedge core_clk);
        #1 chk("align_pulse", 32'h1, align);
        @(posedge core_clk);
        #1 chk("align_end", 32'h0, align);
        chk("enc8", 32'ha51234, {enc_k, enc_disp});
        chk("blk8", 32'h0, {hdr, sos, eidle, byp});
        $display("test to8 done");
    endtask : t_to8
    task automatic t_access();
        rd(12'h020);
        chk("unmapped_data", 32'h0, q);
        chk("unmapped_err", 32'h1, {31'h0, e});
        wr(lpms_pkg::OFF_STAT, 32'hffff_ffff);
        rd(lpms_pkg::OFF_STAT);
        chk("status", 32'h1, q);
        wr(lpms_pkg::OFF_SWAP_GEAR, 32'hffff_ffff);
        rd(lpms_pkg::OFF_SWAP_GEAR);
        chk("swap_mask", lpms_pkg::MSK_SWAP_GEAR, q);
        $display("test access done");
    endtask : t_access
    task automatic t_wclk();
        wclk_pin = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 chk("wclk_off", 32'h0, wclk_sel);
        wr(lpms_pkg::OFF_CTRL, 32'h0000_03f4);
        repeat (2) @(posedge core_clk);
        #1 chk("wclk_on", 32'h1, wclk_sel);
        $display("test wclk done");
    endtask : t_wclk
    initial begin
        {rst_n, wclk_pin, k_pin, disp_pin} = '0;
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_to64();
        t_to8();
        t_access();
        t_wclk();
        chk("apb_timeouts", 32'h0, lpms_apb_model_inst.timeouts);
        complete_run();
    end
    initial begin
        #20000;
        err_total++;
        complete_run();
    end
endmodule : lane_pcs_mode_switch_regs_tb
`default_nettype wire

// ==== lpms_apb_model.sv ====
// APB master model standing in for the fabric mode switch controller.
// Assumes lpms_regs on the same clock; drives just after each edge.
`timescale 1ns/1ps
`default_nettype none
module lpms_apb_model (
    input  wire logic        core_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic switch_done;
    int   timeouts = 0;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, switch_done} = '0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n = 0;
        @(posedge core_clk);
        #1 {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
        @(posedge core_clk);
        #1 penable = 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            n++;
        end
        // A missing answer is counted, never taken silently
        if (pready !== 1'b1) begin
            timeouts++;
        end
        q = prdata;
        e = pslverr;
        // Released psel and penable drop, paddr and pwdata show the inverse, pwrite keeps its last value
        #1 {psel, penable, paddr, pwdata} = {2'b00, ~a, ~d};
    endtask : xfer
    task automatic switch_mode(input logic to64);
        logic [31:0] q;
        logic        e;
        logic [31:0] ctrl;
        switch_done = 1'b0;
        // Widths 6 for 64b66b, 7 for 8b10b
        ctrl = to64 ? 32'h0000_0360 : 32'h0000_03f0;
        xfer(1'b1, lpms_pkg::OFF_CTRL, ctrl | 32'h0000_0003, q, e);
        xfer(1'b1, lpms_pkg::OFF_PATH, to64 ? 32'h22 : 32'h44, q, e);
        // Fabric 1, internal 3, fifo 2, side 0
        xfer(1'b1, lpms_pkg::OFF_CLK, 32'h0000_0af5, q, e);
        xfer(1'b1, lpms_pkg::OFF_CTRL, ctrl, q, e);
        switch_done = 1'b1;
    endtask : switch_mode
endmodule : lpms_apb_model
`default_nettype wire

// ==== lpms_pkg.sv ====
// Constants for the lane PCS mode switch register bank.
// Assumes one reconfiguration clock; offsets are byte addresses.
package lpms_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_SWAP_GEAR = 12'h000;
    localparam logic [11:0] OFF_PATH      = 12'h004;
    localparam logic [11:0] OFF_CLK       = 12'h008;
    localparam logic [11:0] OFF_CTRL      = 12'h00c;
    localparam logic [11:0] OFF_STAT      = 12'h010;
    // octet_swap_and_gear fields
    localparam int unsigned SWAP_POS = 0;
    localparam int unsigned GEAR_POS = 1;
    // lane_path_overlay_select fields
    localparam int unsigned FAB_POS  = 0;
    localparam int unsigned ENC_POS  = 4;
    // lane_clock_source_select fields
    localparam int unsigned FRX_POS  = 0;
    localparam int unsigned FTX_POS  = 2;
    localparam int unsigned IRX_POS  = 4;
    localparam int unsigned ITX_POS  = 6;
    localparam int unsigned FWR_POS  = 8;
    localparam int unsigned FRD_POS  = 10;
    localparam int unsigned SIDE_POS = 12;
    // lane control fields
    localparam int unsigned RXRST_POS  = 0;
    localparam int unsigned TXRST_POS  = 1;
    localparam int unsigned SHARED_POS = 2;
    localparam int unsigned SER_POS    = 4;
    localparam int unsigned DES_POS    = 7;
    // One-hot lane encoding path codes
    localparam logic [3:0] PATH_8B10B  = 4'h4;
    localparam logic [3:0] PATH_64B66B = 4'h2;
    // Values after reset: lane comes up in 8b10b
    localparam logic [31:0] RST_SWAP_GEAR = 32'h0000_0000;
    localparam logic [31:0] RST_PATH      = 32'h0000_0044;
    localparam logic [31:0] RST_CLK       = 32'h0000_0af5;
    localparam logic [31:0] RST_CTRL      = 32'h0000_0370;
    // Writable bit masks
    localparam logic [31:0] MSK_SWAP_GEAR = 32'h0000_0007;
    localparam logic [31:0] MSK_PATH      = 32'h0000_00ff;
    localparam logic [31:0] MSK_CLK       = 32'h0000_1fff;
    localparam logic [31:0] MSK_CTRL      = 32'h0000_03f7;
endpackage : lpms_pkg

// ==== lpms_regs.sv ====
// Lane PCS mode switch registers, reached through the reconfiguration port.
// Assumes an APB3 master on core_clk and fabric tx controls on core_clk.
`timescale 1ns/1ps
`default_nettype none
module lpms_regs (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  fab_tx_ctrl_k,
    input  wire logic [15:0] fab_tx_disp_ctrl,
    input  wire logic        tx_word_clk_pin,
    output logic      [3:0]  lane_encoding_path_select,
    output logic      [3:0]  fabric_path_select,
    output logic             octet_swap_select,
    output logic      [1:0]  fifo_gear_width,
    output logic      [1:0]  fabric_rx_clock_source,
    output logic      [1:0]  fabric_tx_clock_source,
    output logic      [1:0]  internal_rx_clock_source,
    output logic      [1:0]  internal_tx_clock_source,
    output logic      [1:0]  rx_fifo_write_clock_source,
    output logic      [1:0]  tx_fifo_read_clock_source,
    output logic             rx_fifo_clock_side_select,
    output logic      [2:0]  serializer_width_select,
    output logic      [2:0]  deserializer_width_select,
    output logic             pcs_rx_soft_rst,
    output logic             pcs_tx_soft_rst,
    output logic             aligner_search_start,
    output logic      [7:0]  enc_ctrl_k,
    output logic      [15:0] enc_disp_ctrl,
    output logic      [3:0]  blk_hdr,
    output logic             blk_sos,
    output logic             blk_elec_idle,
    output logic             blk_bypass,
    output logic             tx_word_clk_sel
);
    typedef struct packed {
        logic [31:0] swap_gear;
        logic [31:0] path;
        logic [31:0] clk;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        mode8_prev;
        logic        rxrst_prev;
        logic        realign;
        logic        search;
        logic        swap;
        logic [1:0]  gear;
        logic [7:0]  k;
        logic [15:0] disp;
        logic [3:0]  hdr;
        logic        sos;
        logic        idle;
        logic        bypass;
        logic        wclk;
    } lpms_state_t;

    lpms_state_t s_q;
    lpms_state_t s_d;
    logic        rst_sync_n;
    logic        wclk_sync;
    logic        mode8;
    logic        mode64;
    logic        overlay_on;
    logic        mapped;
    logic        wr_en;
    logic        rx_release;
    logic [31:0] status;

    lpms_sync2 #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d_in     (1'b1),
        .q_out    (rst_sync_n)
    );

    lpms_sync2 #(.WIDTH(1), .INIT(1'b0)) u_wclk_sync (
        .core_clk (core_clk),
        .rst_n    (rst_sync_n),
        .d_in     (tx_word_clk_pin),
        .q_out    (wclk_sync)
    );

    always_comb begin
        mode8      = s_q.path[lpms_pkg::ENC_POS +: 4] == lpms_pkg::PATH_8B10B;
        mode64     = s_q.path[lpms_pkg::ENC_POS +: 4] == lpms_pkg::PATH_64B66B;
        overlay_on = s_q.path[lpms_pkg::FAB_POS +: 4]
                     == s_q.path[lpms_pkg::ENC_POS +: 4];
        rx_release = s_q.rxrst_prev && !s_q.ctrl[lpms_pkg::RXRST_POS];
        wr_en      = psel && penable && pwrite && s_q.ready;
        mapped     = paddr == lpms_pkg::OFF_SWAP_GEAR
                     || paddr == lpms_pkg::OFF_PATH
                     || paddr == lpms_pkg::OFF_CLK
                     || paddr == lpms_pkg::OFF_CTRL
                     || paddr == lpms_pkg::OFF_STAT;
        status     = {26'h0, s_q.wclk,
                      s_q.clk[lpms_pkg::SIDE_POS], s_q.realign,
                      !overlay_on, mode64, mode8};
    end

    always_comb begin
        s_d = s_q;
        // Setup phase loads the answer; access phase sees ready high
        s_d.ready = psel && !penable;
        s_d.err   = psel && !penable && !mapped;
        if (psel && !penable) begin
            case (paddr)
                lpms_pkg::OFF_SWAP_GEAR: s_d.rdata = s_q.swap_gear;
                lpms_pkg::OFF_PATH:      s_d.rdata = s_q.path;
                lpms_pkg::OFF_CLK:       s_d.rdata = s_q.clk;
                lpms_pkg::OFF_CTRL:      s_d.rdata = s_q.ctrl;
                lpms_pkg::OFF_STAT:      s_d.rdata = status;
                default:                 s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                lpms_pkg::OFF_SWAP_GEAR:
                    s_d.swap_gear = pwdata & lpms_pkg::MSK_SWAP_GEAR;
                lpms_pkg::OFF_PATH:  s_d.path = pwdata & lpms_pkg::MSK_PATH;
                lpms_pkg::OFF_CLK:   s_d.clk  = pwdata & lpms_pkg::MSK_CLK;
                lpms_pkg::OFF_CTRL:  s_d.ctrl = pwdata & lpms_pkg::MSK_CTRL;
                default:             s_d.ctrl = s_q.ctrl;
            endcase
        end
        s_d.mode8_prev = mode8;
        s_d.rxrst_prev = s_q.ctrl[lpms_pkg::RXRST_POS];
        // Entry into 8b10b needs rx reset; set beats clear
        if (mode8 && !s_q.mode8_prev) begin
            s_d.realign = 1'b1;
        end else if (rx_release) begin
            s_d.realign = 1'b0;
        end
        // Search only on rx reset release
        s_d.search = rx_release && mode8;
        s_d.swap = mode8 && s_q.swap_gear[lpms_pkg::SWAP_POS];
        s_d.gear = mode8 ? s_q.swap_gear[lpms_pkg::GEAR_POS +: 2] : 2'h0;
        s_d.k      = (overlay_on && mode8) ? fab_tx_ctrl_k : 8'h00;
        s_d.disp   = (overlay_on && mode8) ? fab_tx_disp_ctrl : 16'h0000;
        s_d.hdr    = (overlay_on && mode64) ? fab_tx_ctrl_k[3:0] : 4'h0;
        s_d.sos    = overlay_on && mode64 && fab_tx_ctrl_k[4];
        s_d.idle   = overlay_on && mode64 && fab_tx_disp_ctrl[15];
        s_d.bypass = overlay_on && mode64 && fab_tx_disp_ctrl[14];
        // Word clock only with shared clock
        s_d.wclk = s_q.ctrl[lpms_pkg::SHARED_POS] && wclk_sync;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q           <= '0;
            s_q.swap_gear <= lpms_pkg::RST_SWAP_GEAR;
            s_q.path      <= lpms_pkg::RST_PATH;
            s_q.clk       <= lpms_pkg::RST_CLK;
            s_q.ctrl      <= lpms_pkg::RST_CTRL;
            s_q.mode8_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.rdata;
    assign pready  = s_q.ready;
    assign pslverr = s_q.err;
    assign lane_encoding_path_select  = s_q.path[lpms_pkg::ENC_POS +: 4];
    assign fabric_path_select         = s_q.path[lpms_pkg::FAB_POS +: 4];
    assign octet_swap_select          = s_q.swap;
    assign fifo_gear_width            = s_q.gear;
    assign fabric_rx_clock_source     = s_q.clk[lpms_pkg::FRX_POS +: 2];
    assign fabric_tx_clock_source     = s_q.clk[lpms_pkg::FTX_POS +: 2];
    assign internal_rx_clock_source   = s_q.clk[lpms_pkg::IRX_POS +: 2];
    assign internal_tx_clock_source   = s_q.clk[lpms_pkg::ITX_POS +: 2];
    assign rx_fifo_write_clock_source = s_q.clk[lpms_pkg::FWR_POS +: 2];
    assign tx_fifo_read_clock_source  = s_q.clk[lpms_pkg::FRD_POS +: 2];
    assign rx_fifo_clock_side_select  = s_q.clk[lpms_pkg::SIDE_POS];
    assign serializer_width_select    = s_q.ctrl[lpms_pkg::SER_POS +: 3];
    assign deserializer_width_select  = s_q.ctrl[lpms_pkg::DES_POS +: 3];
    assign pcs_rx_soft_rst            = s_q.ctrl[lpms_pkg::RXRST_POS];
    assign pcs_tx_soft_rst            = s_q.ctrl[lpms_pkg::TXRST_POS];
    assign aligner_search_start       = s_q.search;
    assign enc_ctrl_k                 = s_q.k;
    assign enc_disp_ctrl              = s_q.disp;
    assign blk_hdr                    = s_q.hdr;
    assign blk_sos                    = s_q.sos;
    assign blk_elec_idle              = s_q.idle;
    assign blk_bypass                 = s_q.bypass;
    assign tx_word_clk_sel            = s_q.wclk;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence path_is_64;
        lane_encoding_path_select == lpms_pkg::PATH_64B66B
        && fabric_path_select == lpms_pkg::PATH_64B66B;
    endsequence

    sequence rx_rst_falls;
        pcs_rx_soft_rst ##1 !pcs_rx_soft_rst;
    endsequence

    hdr_from_k_a: assert property (
        path_is_64 |=> blk_hdr == $past(fab_tx_ctrl_k[3:0]))
        else $error("header not taken from k bits in 64b66b");
    reserved_drop_a: assert property (
        path_is_64 |=> enc_ctrl_k == 8'h00 && enc_disp_ctrl == 16'h0000)
        else $error("reserved inputs leaked in 64b66b");
    k_pass_8b_a: assert property (
        lane_encoding_path_select == lpms_pkg::PATH_8B10B
        && fabric_path_select == lpms_pkg::PATH_8B10B
        |=> enc_ctrl_k == $past(fab_tx_ctrl_k) && blk_hdr == 4'h0)
        else $error("8b10b control bits not passed");
    swap_gate_a: assert property (
        lane_encoding_path_select != lpms_pkg::PATH_8B10B
        |=> !octet_swap_select)
        else $error("octet swap active outside 8b10b");
    side_flag_a: assert property (
        ##1 pready && psel && !pwrite && paddr == lpms_pkg::OFF_STAT
        |-> prdata[4] == rx_fifo_clock_side_select)
        else $error("side select flag missing in status");
    wclk_gate_a: assert property (
        !s_q.ctrl[lpms_pkg::SHARED_POS] |=> !tx_word_clk_sel)
        else $error("word clock used without shared option");
    search_pulse_a: assert property (
        rx_rst_falls ##0 (lane_encoding_path_select == lpms_pkg::PATH_8B10B)
        |=> aligner_search_start ##1 !aligner_search_start)
        else $error("aligner search pulse missing after rx reset release");
    search_cause_a: assert property (
        aligner_search_start |-> $past(pcs_rx_soft_rst, 2)
        && !$past(pcs_rx_soft_rst)
        && $past(lane_encoding_path_select) == lpms_pkg::PATH_8B10B)
        else $error("aligner search without rx reset release");
    realign_set_a: assert property (
        !s_q.mode8_prev && mode8 |=> s_q.realign)
        else $error("realign pending not set on 8b10b entry");
    apb_answer_a: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
endmodule : lpms_regs
`default_nettype wire

// ==== lpms_sync2.sv ====
// Two-flop synchroniser for levels entering the reconfiguration clock.
// Assumes an asynchronous active-low reset; reset value is a constant.
`timescale 1ns/1ps
`default_nettype none
module lpms_sync2 #(
    parameter int unsigned  WIDTH = 1,
    parameter logic [0:0]   INIT  = 1'b0
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } lpms_sync_t;

    lpms_sync_t s_q;
    lpms_sync_t s_d;

    // First stage feeds only the second
    always_comb begin
        s_d.meta   = d_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= {(2*WIDTH){INIT}};
        end else begin
            s_q <= s_d;
        end
    end

    assign q_out = s_q.stable;
endmodule : lpms_sync2
`default_nettype wire
